// ### hw/apms_consts.svh
// Constants of the amplifier protection and mute sequencer.
// Assumes a 25 MHz main clock and a one-microsecond internal time base.
`ifndef APMS_CONSTS_SVH
`define APMS_CONSTS_SVH

// Clock and time base
`define CLK_NS 40
`define TICK_NS 1000

// Intervals, in their own units
`define RETRY_MS 16
`define SAFE_AREA_PROTECTION_US 300
`define MISS_US 80
`define RAMP_MS 20
`define FMUTE_US 100
`define START_MS 100
`define LOWPOP_MS 300
`define DISCH_MS 1000

// Address-select comparator code for a grounded pin
`define ADDRESS_SELECT_PIN_GND 2'h0
// Legacy standby pin levels
`define STB_OFF 2'h0
`define STB_MUTE 2'h1
`define STB_ON 2'h2
// Clip threshold selections
`define CLIP_2 2'h0
`define CLIP_5 2'h1
`define CLIP_10 2'h2
// Mute control bit positions
`define MB_FAST 0
`define MB_FRONT 1
`define MB_REAR 2
// Gain ramp limits
`define GAIN_MAX 8'hff
`define GAIN_MIN 8'h00

`endif

// ### hw/apms_pkg.sv
// Types shared by the sequencer and its surroundings.
// Assumes apms_consts.svh supplies the numbers.
package apms_pkg;

  // Analog comparator flags of one channel
  typedef struct packed {
    logic short_gnd;
    logic short_sup;
    logic short_load;
    logic vo_lt_1v;
    logic i_gt_4a;
    logic i_gt_8a;
    logic vo_lt_1v75;
    logic miss_gt_1a;
    logic miss_gt_3a;
    logic [2:0] clip;
  } apms_sense_t;

  // Host configuration, held steady between writes
  typedef struct packed {
    logic [2:0] mute_control_bits;
    logic low_pop_disable;
    logic load_fault_diagnostic_pin_disable;
    logic temp_diagnostic_pin_disable;
    logic [1:0] clip_level;
    logic [3:0] clip_to_standby;
    logic [3:0] chan_disable;
  } apms_cfg_t;

  // Recorded fault cause of one channel
  typedef struct packed {
    logic speaker;
    logic safe_area_protection;
    logic short_load;
    logic short_sup;
    logic short_gnd;
  } apms_fault_t;

  typedef struct packed {
    logic power_on_reset_flag;
    logic amp_on;
    logic legacy;
    logic temp_warn;
    logic [3:0] chan_off;
    apms_fault_t [3:0] fault;
  } apms_status_t;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_POR = 6'h02,
    ST_CHARGE = 6'h04,
    ST_RUN = 6'h08,
    ST_FMUTE = 6'h10,
    ST_DISCH = 6'h20
  } apms_state_t;

endpackage : apms_pkg

// ### hw/apms_top.sv
// Standby, mute, protection and diagnostic sequencer of a quad amplifier.
// Assumes analog comparators and pins arrive asynchronously, and host
// configuration lives in the host clock domain as steady levels.
`timescale 1ns/1ps
`include "apms_consts.svh"

module apms_top #(
  parameter int TICK_CYC = `TICK_NS / `CLK_NS,
  parameter int RETRY_TICKS = `RETRY_MS * 1000,
  parameter int SAFE_AREA_PROTECTION_TICKS = `SAFE_AREA_PROTECTION_US,
  parameter int MISS_TICKS = `MISS_US,
  parameter int RAMP_TICKS = `RAMP_MS * 1000,
  parameter int FMUTE_TICKS = `FMUTE_US,
  parameter int START_TICKS = `START_MS * 1000,
  parameter int LOWPOP_TICKS = `LOWPOP_MS * 1000,
  parameter int DISCH_TICKS = `DISCH_MS * 1000,
  // Slave addresses: arbitrary values
  parameter logic [6:0] ADDR_A = 7'h20,
  parameter logic [6:0] ADDR_B = 7'h21,
  parameter logic [6:0] ADDR_C = 7'h22
) (
  // Clocks and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic host_clk_in,
  // Host side, host clock domain
  input wire logic amplifier_start_bit_in,
  input wire apms_pkg::apms_cfg_t cfg_in,
  output apms_pkg::apms_status_t status_out,
  // Pins and analog comparators, asynchronous
  input wire logic [1:0] address_select_pin_in,
  input wire logic standby_pin_in,
  input wire logic [1:0] standby_level_in,
  input wire logic temp_warn_in,
  input wire apms_pkg::apms_sense_t [3:0] sense_in,
  // Open-drain pins
  output logic diagnostic_pin_out,
  output logic diagnostic_pin_oe_out,
  output logic standby_pin_out,
  output logic standby_pin_oe_out,
  // Bus front end
  output logic bus_enable_out,
  output logic [6:0] slave_addr_out,
  output logic legacy_mode_out,
  // Amplifier control
  output logic amp_enable_out,
  output logic [3:0] chan_enable_out,
  output logic [7:0] front_gain_out,
  output logic [7:0] rear_gain_out
);

  localparam int TW = 20;
  localparam int KW = $clog2(TICK_CYC + 1);
  localparam int STEP_TICKS = (RAMP_TICKS / 255 > 0) ? RAMP_TICKS / 255 : 1;
  localparam int SW = 70;

  function automatic logic clip_pick(input logic [2:0] lv,
                                     input logic [1:0] sel);
    logic r;
    r = lv[2];
    case (sel)
      `CLIP_2: r = lv[0];
      `CLIP_5: r = lv[1];
      `CLIP_10: r = lv[2];
      default: r = lv[2];
    endcase
    return r;
  endfunction : clip_pick

  // Input synchronisers; the config crosses as quasi-static levels
  logic [SW-1:0] pin_s1;
  logic [SW-1:0] pin_s2;
  logic [1:0] address_select_pin_s;
  logic stb_s;
  logic [1:0] stb_lvl_s;
  logic temp_s;
  apms_pkg::apms_sense_t [3:0] sense_s;
  apms_pkg::apms_cfg_t cfg_s;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {address_select_pin_in, standby_pin_in, standby_level_in,
                 temp_warn_in, sense_in, cfg_in};
      pin_s2 <= pin_s1;
    end
  end

  assign {address_select_pin_s, stb_s, stb_lvl_s, temp_s, sense_s, cfg_s} = pin_s2;

  // Start bit: toggle in host domain, edge found after three flops
  logic start_tgl;
  logic [2:0] start_s;
  logic start_evt;

  always_ff @(posedge host_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_tgl <= 1'b0;
    end else if (amplifier_start_bit_in) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_s <= '0;
    end else begin
      start_s <= {start_s[1:0], start_tgl};
    end
  end

  assign start_evt = start_s[2] ^ start_s[1];

  // One microsecond time base shared by every interval
  logic [KW-1:0] tick_cnt;
  logic tick;
  logic [TW-1:0] step_cnt;
  logic step;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == KW'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_cnt <= '0;
      step <= 1'b0;
    end else begin
      step <= 1'b0;
      if (tick) begin
        if (step_cnt == TW'(STEP_TICKS - 1)) begin
          step_cnt <= '0;
          step <= 1'b1;
        end else begin
          step_cnt <= step_cnt + 1'b1;
        end
      end
    end
  end

  // Mode decode
  logic legacy;
  logic stb_on;
  logic [TW-1:0] start_len;

  assign legacy = (address_select_pin_s == `ADDRESS_SELECT_PIN_GND);
  assign stb_on = legacy ? (stb_lvl_s != `STB_OFF) : stb_s;
  assign start_len = (legacy || cfg_s.low_pop_disable) ?
                     TW'(START_TICKS) : TW'(LOWPOP_TICKS);

  // Start-up and shut-down sequence
  apms_pkg::apms_state_t state;
  logic [TW-1:0] seq_timer;
  logic timer_done;

  assign timer_done = (seq_timer == '0);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= apms_pkg::ST_OFF;
      seq_timer <= '0;
    end else begin
      if (tick && !timer_done) begin
        seq_timer <= seq_timer - 1'b1;
      end
      unique case (state)
        apms_pkg::ST_OFF: begin
          if (stb_on) begin
            // Legacy skips the start command
            state <= legacy ? apms_pkg::ST_CHARGE : apms_pkg::ST_POR;
            seq_timer <= start_len;
          end
        end
        apms_pkg::ST_POR: begin
          if (!stb_on) begin
            state <= apms_pkg::ST_OFF;
          end else if (start_evt) begin
            state <= apms_pkg::ST_CHARGE;
            seq_timer <= start_len;
          end
        end
        apms_pkg::ST_CHARGE: begin
          if (!stb_on) begin
            // Still muted while charging, so no fast mute needed
            state <= apms_pkg::ST_DISCH;
            seq_timer <= TW'(DISCH_TICKS);
          end else if (timer_done) begin
            state <= apms_pkg::ST_RUN;
          end
        end
        apms_pkg::ST_RUN: begin
          if (!stb_on) begin
            state <= apms_pkg::ST_FMUTE;
            seq_timer <= TW'(FMUTE_TICKS);
          end
        end
        apms_pkg::ST_FMUTE: begin
          if (timer_done) begin
            state <= apms_pkg::ST_DISCH;
            seq_timer <= TW'(DISCH_TICKS);
          end
        end
        apms_pkg::ST_DISCH: begin
          if (timer_done) begin
            state <= apms_pkg::ST_OFF;
          end
        end
      endcase
    end
  end

  logic amp_on;
  assign amp_on = (state == apms_pkg::ST_CHARGE) ||
                  (state == apms_pkg::ST_RUN) ||
                  (state == apms_pkg::ST_FMUTE);

  // Power-on reset flag; a new power-on wins over a start in that cycle
  logic por_flag;
  logic por_set;

  assign por_set = (state == apms_pkg::ST_OFF) && stb_on && !legacy;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      por_flag <= 1'b0;
    end else if (por_set) begin
      por_flag <= 1'b1;
    end else if (start_evt && state == apms_pkg::ST_POR) begin
      por_flag <= 1'b0;
    end
  end

  // Mute targets and gain ramps, index 0 front, 1 rear
  logic fast_mute;
  logic [1:0] pair_mute;
  logic [1:0][7:0] gain;

  assign fast_mute = (state == apms_pkg::ST_FMUTE) ||
                     (!legacy && cfg_s.mute_control_bits[`MB_FAST]);
  assign pair_mute[0] = legacy ? (stb_lvl_s == `STB_MUTE) :
                        cfg_s.mute_control_bits[`MB_FRONT];
  assign pair_mute[1] = legacy ? (stb_lvl_s == `STB_MUTE) :
                        cfg_s.mute_control_bits[`MB_REAR];

  for (genvar p = 0; p < 2; p++) begin : g_pair
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        gain[p] <= `GAIN_MIN;
      end else if (state != apms_pkg::ST_RUN || fast_mute) begin
        // Cut at once: well inside the fast mute limit
        gain[p] <= `GAIN_MIN;
      end else if (step) begin
        if (pair_mute[p] && gain[p] != `GAIN_MIN) begin
          gain[p] <= gain[p] - 8'h01;
        end else if (!pair_mute[p] && gain[p] != `GAIN_MAX) begin
          gain[p] <= gain[p] + 8'h01;
        end
      end
    end
  end

  // Per-channel protection
  logic [3:0] fault_off;
  logic [3:0] chan_dis;
  logic [3:0] clip_hit;
  apms_pkg::apms_fault_t [3:0] fault_rec;

  assign chan_dis = legacy ? 4'h0 : cfg_s.chan_disable;

  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [TW-1:0] safe_area_protection_cnt;
    logic [TW-1:0] miss_cnt;
    logic [TW-1:0] retry_cnt;
    logic shorted;
    logic safe_area_protection_low;
    logic safe_area_protection_high;
    logic missing;
    logic safe_area_protection_q;
    logic miss_q;
    logic trip;

    assign shorted = sense_s[c].short_gnd | sense_s[c].short_sup |
                     sense_s[c].short_load;
    assign safe_area_protection_low = sense_s[c].vo_lt_1v & sense_s[c].i_gt_4a;
    assign safe_area_protection_high = ~sense_s[c].vo_lt_1v & sense_s[c].i_gt_8a;
    assign missing = sense_s[c].vo_lt_1v75 ? sense_s[c].miss_gt_1a :
                     sense_s[c].miss_gt_3a;
    assign safe_area_protection_q = safe_area_protection_low && safe_area_protection_cnt > TW'(SAFE_AREA_PROTECTION_TICKS);
    assign miss_q = missing && miss_cnt >= TW'(MISS_TICKS);
    assign trip = amp_on && !fault_off[c] && !chan_dis[c] &&
                  (shorted || safe_area_protection_high || safe_area_protection_q || miss_q);
    assign clip_hit[c] = clip_pick(sense_s[c].clip,
                                   legacy ? `CLIP_2 : cfg_s.clip_level);

    // Qualifying counters run on the shared tick
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        safe_area_protection_cnt <= '0;
        miss_cnt <= '0;
      end else begin
        if (!safe_area_protection_low || fault_off[c]) begin
          safe_area_protection_cnt <= '0;
        end else if (tick && safe_area_protection_cnt <= TW'(SAFE_AREA_PROTECTION_TICKS)) begin
          safe_area_protection_cnt <= safe_area_protection_cnt + 1'b1;
        end
        if (!missing || fault_off[c]) begin
          miss_cnt <= '0;
        end else if (tick && miss_cnt < TW'(MISS_TICKS)) begin
          miss_cnt <= miss_cnt + 1'b1;
        end
      end
    end

    // Off for the retry period; host disable freezes the retry
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        fault_off[c] <= 1'b0;
        retry_cnt <= '0;
      end else if (trip) begin
        fault_off[c] <= 1'b1;
        retry_cnt <= TW'(RETRY_TICKS);
      end else if (fault_off[c] && tick && !chan_dis[c]) begin
        if (retry_cnt <= TW'(1)) begin
          fault_off[c] <= 1'b0;
          retry_cnt <= '0;
        end else begin
          retry_cnt <= retry_cnt - 1'b1;
        end
      end
    end

    // Cause record: a new trip wins over a start-bit clear
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        fault_rec[c] <= '0;
      end else if (trip) begin
        fault_rec[c] <= {miss_q, safe_area_protection_high | safe_area_protection_q,
                         sense_s[c].short_load, sense_s[c].short_sup,
                         sense_s[c].short_gnd};
      end else if (start_evt) begin
        fault_rec[c] <= '0;
      end
    end
  end

  // Diagnostic pin and second clip pin, both pulled low when active
  logic diagnostic_pin_low;
  logic stb_low;
  logic [3:0] to_stb;

  assign to_stb = legacy ? 4'h0 : cfg_s.clip_to_standby;
  always_comb begin
    diagnostic_pin_low = por_flag;
    if (legacy) begin
      diagnostic_pin_low = diagnostic_pin_low | (amp_on && (|clip_hit)) | temp_s | (|fault_off);
    end else begin
      diagnostic_pin_low = diagnostic_pin_low |
                 (!cfg_s.load_fault_diagnostic_pin_disable && (|fault_off)) |
                 (!cfg_s.temp_diagnostic_pin_disable && temp_s) |
                 (amp_on && (|(clip_hit & ~to_stb)));
    end
    stb_low = amp_on && (|(clip_hit & to_stb));
  end

  // Slave address from the resistor code
  logic [6:0] next_addr;
  always_comb begin
    unique case (address_select_pin_s)
      2'h1: next_addr = ADDR_A;
      2'h2: next_addr = ADDR_B;
      2'h3: next_addr = ADDR_C;
      default: next_addr = 7'h00;
    endcase
  end

  // Registered pin and control outputs
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      diagnostic_pin_out <= 1'b0;
      diagnostic_pin_oe_out <= 1'b0;
      standby_pin_out <= 1'b0;
      standby_pin_oe_out <= 1'b0;
      bus_enable_out <= 1'b0;
      slave_addr_out <= 7'h00;
      legacy_mode_out <= 1'b0;
      amp_enable_out <= 1'b0;
      chan_enable_out <= 4'h0;
      front_gain_out <= `GAIN_MIN;
      rear_gain_out <= `GAIN_MIN;
    end else begin
      diagnostic_pin_out <= 1'b0;
      diagnostic_pin_oe_out <= diagnostic_pin_low;
      standby_pin_out <= 1'b0;
      standby_pin_oe_out <= stb_low;
      bus_enable_out <= !legacy && stb_s;
      slave_addr_out <= next_addr;
      legacy_mode_out <= legacy;
      amp_enable_out <= amp_on;
      chan_enable_out <= amp_on ? ~(fault_off | chan_dis) : 4'h0;
      front_gain_out <= gain[0];
      rear_gain_out <= gain[1];
    end
  end

  // Status: readable whatever the pin enables say
  apms_pkg::apms_status_t stat_q;
  apms_pkg::apms_status_t stat_s1;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_q <= '0;
    end else begin
      stat_q <= {por_flag, amp_on, legacy, temp_s,
                 fault_off | chan_dis, fault_rec};
    end
  end

  // Each status bit crosses as an independent level
  always_ff @(posedge host_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_s1 <= '0;
      status_out <= '0;
    end else begin
      stat_s1 <= stat_q;
      status_out <= stat_s1;
    end
  end

endmodule : apms_top

// ### testbench/apms_monitor.sv
// Concurrent checks on the sequencer's ports, main clock domain only.
// Assumes the bench holds asynchronous inputs steady for several cycles.
`timescale 1ns/1ps
module apms_monitor (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Watched inputs
  input wire apms_pkg::apms_cfg_t cfg_in,
  input wire logic [1:0] address_select_pin_in,
  input wire logic standby_pin_in,
  input wire apms_pkg::apms_sense_t [3:0] sense_in,
  // Watched outputs
  input wire logic diagnostic_pin_oe_out,
  input wire logic standby_pin_oe_out,
  input wire logic legacy_mode_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic amp_enable_out,
  input wire logic [3:0] chan_enable_out,
  input wire logic [7:0] front_gain_out,
  input wire logic [7:0] rear_gain_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  AST_LEGACY: assert property ((address_select_pin_in == 2'h0)[*4]
    |-> ##[0:4] legacy_mode_out) else $error("legacy mode not entered");
  AST_ADDR: assert property ((address_select_pin_in != 2'h0)[*4]
    |-> ##[0:4] (slave_addr_out == 7'h1f + address_select_pin_in))
    else $error("slave address not decoded");
  AST_CLIP_ROUTE: assert property ((sense_in[0].clip == 3'h7
    && cfg_in.clip_to_standby == 4'h1 && !legacy_mode_out)[*6]
    |-> standby_pin_oe_out) else $error("clip not on standby pin");
  AST_SHORT_OFF: assert property ((sense_in[0][11:9] != 3'h0)[*4]
    |-> ##[0:3] !chan_enable_out[0]) else $error("shorted channel on");
  AST_SHORT_FLAG: assert property ((sense_in[0][11:9] != 3'h0
    && !cfg_in.load_fault_diagnostic_pin_disable && amp_enable_out
    && !legacy_mode_out)[*6] |-> ##[0:2] diagnostic_pin_oe_out)
    else $error("short not flagged");
  AST_RETRY_HOLD: assert property ($fell(chan_enable_out[0])
    && amp_enable_out |-> (!chan_enable_out[0])[*8])
    else $error("channel back on too soon");
  AST_HOST_OFF: assert property (((cfg_in.chan_disable != 4'h0)
    && $stable(cfg_in.chan_disable) && !legacy_mode_out)[*6]
    |-> (cfg_in.chan_disable & chan_enable_out) == 4'h0)
    else $error("disabled channel on");
  AST_POR_FLAG: assert property ($rose(standby_pin_in)
    && !legacy_mode_out && !amp_enable_out
    |-> ##[2:8] diagnostic_pin_oe_out) else $error("reset flag not shown");
  AST_FAST_MUTE: assert property ((cfg_in.mute_control_bits[0]
    && !legacy_mode_out)[*6] |-> front_gain_out == 8'h00
    && rear_gain_out == 8'h00) else $error("fast mute not applied");
  AST_STBY_MUTE: assert property ($fell(standby_pin_in)
    && !legacy_mode_out && amp_enable_out |-> ##[1:6]
    (front_gain_out == 8'h00 && rear_gain_out == 8'h00))
    else $error("no fast mute on standby");
endmodule : apms_monitor

bind apms_top apms_monitor u_mon (.mclk_in, .nrst_in, .cfg_in,
  .address_select_pin_in, .standby_pin_in, .sense_in,
  .diagnostic_pin_oe_out, .standby_pin_oe_out, .legacy_mode_out,
  .slave_addr_out, .amp_enable_out, .chan_enable_out, .front_gain_out,
  .rear_gain_out);

// ### testbench/apms_host.sv
// Host processor model: turns a bench request toggle into one start-bit
// write. Assumes requests toggle at least several main cycles apart.
`timescale 1ns/1ps
module apms_host (
  // Host clock and reset
  input wire logic host_clk_in,
  input wire logic nrst_in,
  // Bench request and start-bit write
  input wire logic req_in,
  output logic start_out
);
  logic req_q;
  // One host cycle wide, as a single register write would be
  always_ff @(posedge host_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_q <= 1'b0;
      start_out <= 1'b0;
    end else begin
      req_q <= req_in;
      start_out <= req_in ^ req_q;
    end
  end
endmodule : apms_host

// ### testbench/apms_top_tb.sv
// Self-checking bench of the protection and mute sequencer.
// Assumes shortened timers; host clock of 6 ns, unrelated in phase.
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  err_count++; $display("Error %s exp %0h got %0h", n, e, a); end end
`define WAIT(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin \
  @(negedge mclk_in); k++; end end
module apms_top_tb;
  localparam int TC = 10;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic host_clk_in = 1'b0;
  logic start_req = 1'b0;
  logic amplifier_start_bit_in;
  logic standby_pin_in = 1'b0;
  logic temp_warn_in = 1'b0;
  logic [1:0] address_select_pin_in = 2'h1;
  logic [1:0] standby_level_in = 2'h0;
  apms_pkg::apms_cfg_t cfg_in = '0;
  apms_pkg::apms_sense_t [3:0] sense_in = '0;
  apms_pkg::apms_status_t status_out;
  logic diagnostic_pin_out, diagnostic_pin_oe_out, standby_pin_out;
  logic standby_pin_oe_out, bus_enable_out, legacy_mode_out;
  logic amp_enable_out;
  logic [6:0] slave_addr_out;
  logic [3:0] chan_enable_out;
  logic [7:0] front_gain_out, rear_gain_out;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #20 mclk_in = ~mclk_in;
  initial begin
    #1.3;
    forever #3 host_clk_in = ~host_clk_in;
  end

  // Protection qualifiers and fast mute keep their full tick counts
  apms_top #(.RETRY_TICKS(40), .RAMP_TICKS(255), .START_TICKS(20),
    .LOWPOP_TICKS(40), .DISCH_TICKS(20), .TICK_CYC(TC)) dut (
    .mclk_in, .nrst_in, .host_clk_in, .amplifier_start_bit_in, .cfg_in,
    .status_out, .address_select_pin_in, .standby_pin_in,
    .standby_level_in, .temp_warn_in, .sense_in, .diagnostic_pin_out,
    .diagnostic_pin_oe_out, .standby_pin_out, .standby_pin_oe_out,
    .bus_enable_out, .slave_addr_out, .legacy_mode_out, .amp_enable_out,
    .chan_enable_out, .front_gain_out, .rear_gain_out);
  apms_host host (.host_clk_in, .nrst_in, .req_in(start_req),
    .start_out(amplifier_start_bit_in));

  task end_sim;
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim;
    end
  end

  task host_start;
    start_req = ~start_req;
    repeat (8) @(negedge mclk_in);
  endtask : host_start

  task t_bus_up;
    standby_pin_in = 1'b1;
    `WAIT(diagnostic_pin_oe_out === 1'b1, 20)
    `CHK("flag_pin", 1'b1, diagnostic_pin_oe_out)
    `CHK("bus_en", 1'b1, bus_enable_out)
    `CHK("addr", 7'h20, slave_addr_out)
    `CHK("drive_low", 2'h0, {diagnostic_pin_out, standby_pin_out})
    repeat (4) @(negedge mclk_in);
    `CHK("por_set", 1'b1, status_out.power_on_reset_flag)
    host_start;
    `CHK("por_clr", 1'b0, status_out.power_on_reset_flag)
    `CHK("pin_free", 1'b0, diagnostic_pin_oe_out)
    `CHK("amp_on", 1'b1, amp_enable_out)
    `WAIT(front_gain_out === 8'hff, 300 * TC)
    `CHK("gain_up", 8'hff, rear_gain_out)
    `CHK("chans", 4'hf, chan_enable_out)
  endtask : t_bus_up

  task t_prot;
    sense_in[0].short_gnd = 1'b1;
    repeat (6) @(negedge mclk_in);
    `CHK("short_off", 4'he, chan_enable_out)
    `CHK("short_rec", 5'h01, status_out.fault[0])
    `CHK("short_pin", 1'b1, diagnostic_pin_oe_out)
    sense_in[0].short_gnd = 1'b0;
    repeat (20 * TC) @(negedge mclk_in);
    `CHK("retry_wait", 1'b0, chan_enable_out[0])
    `WAIT(chan_enable_out[0] === 1'b1, 30 * TC)
    `CHK("retry_on", 1'b1, chan_enable_out[0])
    sense_in[1].short_load = 1'b1;
    repeat (6) @(negedge mclk_in);
    cfg_in.chan_disable = 4'h2;
    sense_in[1].short_load = 1'b0;
    repeat (50 * TC) @(negedge mclk_in);
    `CHK("host_off", 1'b0, chan_enable_out[1])
    `CHK("load_rec", 5'h04, status_out.fault[1])
    cfg_in.chan_disable = 4'h0;
    repeat (6) @(negedge mclk_in);
    `CHK("retry_held", 1'b0, chan_enable_out[1])
    sense_in[2] = 12'h180;
    repeat (250 * TC) @(negedge mclk_in);
    `CHK("area_brief", 1'b1, chan_enable_out[2])
    sense_in[2] = 12'h000;
    repeat (2) @(negedge mclk_in);
    sense_in[2] = 12'h180;
    repeat (310 * TC) @(negedge mclk_in);
    `CHK("area_long", 1'b0, chan_enable_out[2])
    sense_in[2] = 12'h000;
    // Missing current at low output swing, held past its qualifying time
    sense_in[0] = 12'h030;
    repeat (60 * TC) @(negedge mclk_in);
    `CHK("miss_brief", 1'b1, chan_enable_out[0])
    repeat (30 * TC) @(negedge mclk_in);
    `CHK("miss_long", 1'b0, chan_enable_out[0])
    `CHK("miss_rec", 5'h10, status_out.fault[0])
    sense_in[0] = 12'h000;
    sense_in[3] = 12'h040;
    repeat (6) @(negedge mclk_in);
    `CHK("high_amp", 1'b0, chan_enable_out[3])
    sense_in[3] = 12'h000;
    `WAIT(chan_enable_out === 4'hf, 60 * TC)
    `CHK("all_back", 4'hf, chan_enable_out)
  endtask : t_prot

  task t_diagnostic_pin;
    host_start;
    for (int i = 0; i < 3; i++) begin
      cfg_in.clip_level = 2'(i);
      sense_in[0].clip = 3'((1 << i) - 1);
      repeat (6) @(negedge mclk_in);
      `CHK("clip_below", 1'b0, diagnostic_pin_oe_out)
      sense_in[0].clip = 3'((2 << i) - 1);
      repeat (6) @(negedge mclk_in);
      `CHK("clip_above", 1'b1, diagnostic_pin_oe_out)
    end
    cfg_in.clip_to_standby = 4'h1;
    cfg_in.temp_diagnostic_pin_disable = 1'b1;
    cfg_in.load_fault_diagnostic_pin_disable = 1'b1;
    temp_warn_in = 1'b1;
    sense_in[1].short_sup = 1'b1;
    repeat (10) @(negedge mclk_in);
    `CHK("clip_route", 1'b1, standby_pin_oe_out)
    `CHK("pin_quiet", 1'b0, diagnostic_pin_oe_out)
    `CHK("temp_read", 1'b1, status_out.temp_warn)
    `CHK("sup_read", 5'h02, status_out.fault[1])
    sense_in = '0;
    temp_warn_in = 1'b0;
    // Everything clear but low_pop_disable, in one write
    cfg_in = 16'h1000;
    `WAIT(chan_enable_out === 4'hf, 60 * TC)
    host_start;
    `CHK("pin_clear", 1'b0, diagnostic_pin_oe_out)
  endtask : t_diagnostic_pin

  task t_mute;
    cfg_in.mute_control_bits = 3'h2;
    repeat (10 * TC) @(negedge mclk_in);
    `CHK("soft_ramp", 1'b1, front_gain_out != 8'h00)
    `WAIT(front_gain_out === 8'h00, 300 * TC)
    `CHK("front_mute", 8'h00, front_gain_out)
    `CHK("rear_live", 8'hff, rear_gain_out)
    cfg_in.mute_control_bits = 3'h4;
    `WAIT(rear_gain_out === 8'h00 && front_gain_out === 8'hff, 300 * TC)
    `CHK("rear_mute", 8'h00, rear_gain_out)
    `CHK("front_live", 8'hff, front_gain_out)
    cfg_in.mute_control_bits = 3'h5;
    repeat (8) @(negedge mclk_in);
    `CHK("fast_mute", 8'h00, front_gain_out)
    cfg_in.mute_control_bits = 3'h0;
    repeat (10 * TC) @(negedge mclk_in);
    `CHK("soft_back", 1'b1, front_gain_out != 8'hff)
    `CHK("soft_rise", 1'b1, front_gain_out != 8'h00)
    `WAIT(front_gain_out === 8'hff && rear_gain_out === 8'hff, 300 * TC)
    `CHK("unmuted", 8'hff, rear_gain_out)
  endtask : t_mute

  task t_down;
    standby_pin_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    `CHK("down_mute", 8'h00, front_gain_out | rear_gain_out)
    `CHK("still_on", 1'b1, amp_enable_out)
    `WAIT(amp_enable_out === 1'b0, 120 * TC)
    `CHK("amp_off", 1'b0, amp_enable_out)
    `WAIT(bus_enable_out === 1'b0, 40 * TC)
    `CHK("bus_off", 1'b0, bus_enable_out)
  endtask : t_down

  task t_legacy;
    address_select_pin_in = 2'h3;
    repeat (6) @(negedge mclk_in);
    `CHK("addr_c", 7'h22, slave_addr_out)
    address_select_pin_in = 2'h0;
    // Let the discharge from the bus-mode shutdown run out first
    repeat (30 * TC) @(negedge mclk_in);
    `CHK("legacy", 1'b1, legacy_mode_out)
    `CHK("no_addr", 7'h00, slave_addr_out)
    standby_level_in = 2'h2;
    `WAIT(amp_enable_out === 1'b1, 10)
    `CHK("direct_on", 1'b1, amp_enable_out)
    `WAIT(front_gain_out === 8'hff, 300 * TC)
    `CHK("lg_up", 8'hff, front_gain_out)
    standby_level_in = 2'h0;
    repeat (6) @(negedge mclk_in);
    `CHK("lg_fast", 8'h00, front_gain_out | rear_gain_out)
    `WAIT(amp_enable_out === 1'b0, 120 * TC)
    `CHK("lg_off", 1'b0, amp_enable_out)
    repeat (30 * TC) @(negedge mclk_in);
    standby_level_in = 2'h1;
    `WAIT(amp_enable_out === 1'b1, 10)
    `CHK("mute_on", 1'b1, amp_enable_out)
    repeat (40 * TC) @(negedge mclk_in);
    `CHK("stay_mute", 8'h00, front_gain_out)
    standby_level_in = 2'h2;
    repeat (10 * TC) @(negedge mclk_in);
    `CHK("lg_ramp", 1'b1, front_gain_out != 8'h00)
    `CHK("lg_slow", 1'b1, front_gain_out != 8'hff)
  endtask : t_legacy

  initial begin
    cfg_in.low_pop_disable = 1'b1;
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    t_bus_up;
    t_prot;
    t_diagnostic_pin;
    t_mute;
    t_down;
    t_legacy;
    end_sim;
  end
endmodule : apms_top_tb
